// ===== hdl/sdl_pkg.sv
// Purpose: shared constants, types and decode helpers of the serial
//          converter load logic (device end and host end)
// Assumes: system clock of 250 MHz on both ends
// Notes:   cycle counts are derived from nanosecond figures here

package sdl_pkg;

	// word layout
	localparam int WORD_W = 16;
	localparam int SEG_W  = 15;
	localparam int LAD_W  = 12;
	localparam int TOP_W  = 4;

	// value after reset of the converter latch: all zeros
	localparam logic [WORD_W-1:0] LATCH_RST = 16'h0000;

	// clock figures
	localparam int CLK_MHZ      = 250;
	localparam int SCLK_MAX_MHZ = 25;

	// host-side link timing, in ns
	localparam int T_CS_SETUP_NS = 15;
	localparam int T_CS_HOLD_NS  = 20;
	localparam int T_CS_GAP_NS   = 30;
	localparam int T_LOAD_PW_NS  = 30;

	// least time in ns to whole clock cycles, rounded up, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int CNT_W = 4;
	// half period of the serial clock, rounded up so the rate stays <= max
	localparam int SCLK_HALF_I =
		(CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
	localparam logic [CNT_W-1:0] SCLK_HALF_CYC = CNT_W'(SCLK_HALF_I);
	localparam logic [CNT_W-1:0] CS_SETUP_CYC  =
		CNT_W'(ns_to_cyc(T_CS_SETUP_NS));
	localparam logic [CNT_W-1:0] CS_HOLD_CYC   =
		CNT_W'(ns_to_cyc(T_CS_HOLD_NS));
	localparam logic [CNT_W-1:0] CS_GAP_CYC    =
		CNT_W'(ns_to_cyc(T_CS_GAP_NS));
	localparam logic [CNT_W-1:0] LOAD_PW_CYC   =
		CNT_W'(ns_to_cyc(T_LOAD_PW_NS));
	localparam logic [CNT_W-1:0] BIT_LAST      = 4'hf;

	localparam int FIFO_DEPTH = 16;

	// host sequencer states, gray along the frame path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_SHIFT = 3'b011,
		ST_HOLD  = 3'b010,
		ST_GAP   = 3'b110,
		ST_LOAD  = 3'b111
	} sdl_state_t;

	// thermometer code of the top nibble: bit i set when top > i
	function automatic logic [SEG_W-1:0] therm_decode(
		input logic [TOP_W-1:0] top);
		logic [SEG_W-1:0] t;
		t = '0;
		for (int i = 0; i < SEG_W; i++) begin
			t[i] = (top > TOP_W'(i));
		end
		return t;
	endfunction

endpackage

// ===== hdl/sdl_link_if.sv
// Purpose: three-wire serial link plus load strobe between the ends
// Assumes: host drives every wire; device only listens
// Notes:   the serial clock doubles as the device's link-domain clock

`timescale 1ns/100ps

interface sdl_link_if;
	logic sclk;
	logic din;
	logic cs_n;
	logic latch_load_strobe_n;

	modport host (
		output sclk,
		output din,
		output cs_n,
		output latch_load_strobe_n
	);

	modport dev (
		input  sclk,
		input  din,
		input  cs_n,
		input  latch_load_strobe_n
	);
endinterface

// ===== hdl/sdl_device.sv
// Purpose: device end: serial shift register, input register, converter
//          latch and segmented switch decode
// Assumes: host keeps the link contract; clk_in is faster than sclk
// Notes:   shift register lives on sclk, everything else on clk_in
//
// Contract
// (R1) shift din on sclk rise while select low
// (R2) sixteen-bit words, most significant bit first
// (R3) host opens frame with select falling edge
// (R4) select rising edge moves shift word onward
// (R5) strobe falling copies input register into latch
// (R6) host strobes only after select returns high
// (R7) host holds strobe high during shifting; the host holds it low throughout when async_load_in is low
// (R8) strobe held low: latch on select rise
// (R9) power-up latch code zero, known output
// (R10) serial clock at most 25 MHz
// (R11) top nibble thermometer, low twelve direct
// (R12) latch code is unsigned straight binary
// (R13) latch cleared at reset, shift register not
// (R14) last sixteen bits kept; pad short words
// (R15) select high: clock and data ignored
// (R16) latch changes only on load events

`timescale 1ns/100ps

module sdl_device
	import sdl_pkg::*;
(
	input  wire logic                       clk_in,
	input  wire logic                       reset_in,
	sdl_link_if.dev                         link,
	output logic [sdl_pkg::WORD_W-1:0]      latch_code_out,
	output logic [sdl_pkg::SEG_W-1:0]       segment_out,
	output logic [sdl_pkg::LAD_W-1:0]       ladder_out,
	output logic [sdl_pkg::WORD_W-1:0]      input_word_out,
	output logic                            word_taken_out,
	output logic                            latch_update_out
);
	import sdl_pkg::*;

	// ---------------- link domain (sclk) ----------------

	logic [WORD_W-1:0] shift_ff;
	logic [WORD_W-1:0] nxt_shift;

	// shift in msb first; older bits fall off the top, so only the last
	// sixteen of a long frame stay and a short frame keeps old low bits
	always_comb begin
		if (!link.cs_n) begin
			nxt_shift = {shift_ff[WORD_W-2:0], link.din}; // R1 R2 R14
		end else begin
			nxt_shift = shift_ff; // R15
		end
	end

	// no reset on purpose: the shift register powers up undefined
	always_ff @(posedge link.sclk) begin
		shift_ff <= nxt_shift; // R13 R10
	end

	// ---------------- system domain (clk_in) ----------------

	logic cs_meta_ff;
	logic cs_sync_ff;
	logic cs_prev_ff;
	logic ld_meta_ff;
	logic ld_sync_ff;
	logic ld_prev_ff;
	logic nxt_cs_meta;
	logic nxt_cs_sync;
	logic nxt_cs_prev;
	logic nxt_ld_meta;
	logic nxt_ld_sync;
	logic nxt_ld_prev;
	logic cs_rise;
	logic ld_fall;

	// two-stage synchronisers, a third stage only for edge detection
	always_comb begin
		nxt_cs_meta = link.cs_n;
		nxt_cs_sync = cs_meta_ff;
		nxt_cs_prev = cs_sync_ff;
		nxt_ld_meta = link.latch_load_strobe_n;
		nxt_ld_sync = ld_meta_ff;
		nxt_ld_prev = ld_sync_ff;
	end

	// idle levels at reset so no false edge appears on release
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cs_meta_ff <= 1'b1;
			cs_sync_ff <= 1'b1;
			cs_prev_ff <= 1'b1;
			ld_meta_ff <= 1'b1;
			ld_sync_ff <= 1'b1;
			ld_prev_ff <= 1'b1;
		end else begin
			cs_meta_ff <= nxt_cs_meta;
			cs_sync_ff <= nxt_cs_sync;
			cs_prev_ff <= nxt_cs_prev;
			ld_meta_ff <= nxt_ld_meta;
			ld_sync_ff <= nxt_ld_sync;
			ld_prev_ff <= nxt_ld_prev;
		end
	end

	// events seen only after synchronisation
	always_comb begin
		cs_rise = cs_sync_ff & ~cs_prev_ff;
		ld_fall = ~ld_sync_ff & ld_prev_ff;
	end

	logic [WORD_W-1:0] inreg_ff;
	logic [WORD_W-1:0] latch_ff;
	logic [SEG_W-1:0]  seg_ff;
	logic [LAD_W-1:0]  lad_ff;
	logic              taken_ff;
	logic              upd_ff;
	logic [WORD_W-1:0] nxt_inreg;
	logic [WORD_W-1:0] nxt_latch;
	logic [SEG_W-1:0]  nxt_seg;
	logic [LAD_W-1:0]  nxt_lad;
	logic              nxt_taken;
	logic              nxt_upd;

	// the shift word crosses without its own synchroniser: sclk has
	// stopped before select rises, and select itself is synchronised,
	// so the word has been still for at least two clk_in edges when read
	always_comb begin
		nxt_inreg = inreg_ff;
		nxt_latch = latch_ff;
		nxt_taken = 1'b0;
		nxt_upd   = 1'b0;
		if (cs_rise) begin
			nxt_inreg = shift_ff; // R4
			nxt_taken = 1'b1;
		end
		if (cs_rise && !ld_sync_ff) begin
			// strobe held low: the fresh word goes straight through
			nxt_latch = shift_ff; // R8
			nxt_upd   = 1'b1;
		end else if (ld_fall) begin
			nxt_latch = inreg_ff; // R5 R16
			nxt_upd   = 1'b1;
		end
		// plain unsigned code; top nibble drives the fifteen segments
		nxt_seg = therm_decode(nxt_latch[WORD_W-1:LAD_W]); // R11 R12
		nxt_lad = nxt_latch[LAD_W-1:0]; // R11
	end

	// latch and switch controls cleared at reset: zero code out
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			inreg_ff <= LATCH_RST;
			latch_ff <= LATCH_RST; // R9 R13
			seg_ff   <= '0;
			lad_ff   <= '0;
			taken_ff <= 1'b0;
			upd_ff   <= 1'b0;
		end else begin
			inreg_ff <= nxt_inreg;
			latch_ff <= nxt_latch;
			seg_ff   <= nxt_seg;
			lad_ff   <= nxt_lad;
			taken_ff <= nxt_taken;
			upd_ff   <= nxt_upd;
		end
	end

	// all outputs straight from flip-flops
	assign latch_code_out   = latch_ff;
	assign segment_out      = seg_ff;
	assign ladder_out       = lad_ff;
	assign input_word_out   = inreg_ff;
	assign word_taken_out   = taken_ff;
	assign latch_update_out = upd_ff;

endmodule

// ===== hdl/sdl_host.sv
// Purpose: host end: word fifo feeding a serial link master that frames,
//          shifts and optionally strobes the converter latch
// Assumes: clk_in at 250 MHz; the serial clock is divided from it
// Notes:   the fifo fills while a frame is in flight

`timescale 1ns/100ps

module sdl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	output logic [WIDTH-1:0]      out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ff;
	logic [AW:0]      rd_ff;
	logic [AW:0]      nxt_wr;
	logic [AW:0]      nxt_rd;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	// extra pointer bit tells full from empty
	always_comb begin
		empty  = (wr_ff == rd_ff);
		full   = (wr_ff[AW] != rd_ff[AW]) &&
		         (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
		push   = in_valid_in && !full;
		pop    = out_ready_in && !empty;
		nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
		end
	end

	// storage has no reset; reads are gated by empty
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ff[AW-1:0]] <= in_data_in;
		end
	end

	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = mem[rd_ff[AW-1:0]];
endmodule

module sdl_host
	import sdl_pkg::*;
(
	input  wire logic                       clk_in,
	input  wire logic                       reset_in,
	input  wire logic [sdl_pkg::WORD_W-1:0] word_in,
	input  wire logic                       word_valid_in,
	output logic                            word_ready_out,
	input  wire logic                       async_load_in,
	output logic                            busy_out,
	sdl_link_if.host                        link
);
	import sdl_pkg::*;

	logic [WORD_W-1:0] fifo_data;
	logic              fifo_valid;
	logic              fifo_pop;

	sdl_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.in_data_in    (word_in),
		.in_valid_in   (word_valid_in),
		.in_ready_out  (word_ready_out),
		.out_data_out  (fifo_data),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop)
	);

	sdl_state_t        state_ff;
	sdl_state_t        nxt_state;
	logic [CNT_W-1:0]  cnt_ff;
	logic [CNT_W-1:0]  nxt_cnt;
	logic [CNT_W-1:0]  bit_ff;
	logic [CNT_W-1:0]  nxt_bit;
	logic [WORD_W-1:0] sh_ff;
	logic [WORD_W-1:0] nxt_sh;
	logic              mode_ff;
	logic              nxt_mode;
	logic              sclk_ff;
	logic              nxt_sclk;
	logic              cs_n_ff;
	logic              nxt_cs_n;
	logic              din_ff;
	logic              nxt_din;
	logic              ld_n_ff;
	logic              nxt_ld_n;

	// only the idle sequencer drains the fifo, so back-pressure is real
	assign fifo_pop = (state_ff == ST_IDLE) && fifo_valid;

	// frame sequencer: select low, sixteen clocks, select high, gap,
	// then an optional strobe pulse in asynchronous update mode
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_bit   = bit_ff;
		nxt_sh    = sh_ff;
		nxt_mode  = mode_ff;
		nxt_sclk  = sclk_ff;
		nxt_cs_n  = cs_n_ff;
		nxt_din   = din_ff;
		nxt_ld_n  = ld_n_ff;
		unique case (state_ff)
			ST_IDLE: begin
				// in synchronous mode the strobe rests low
				nxt_ld_n = async_load_in; // R8
				if (fifo_valid) begin
					nxt_mode  = async_load_in;
					nxt_ld_n  = async_load_in; // R7
					nxt_sh    = fifo_data;
					nxt_din   = fifo_data[WORD_W-1]; // R2
					nxt_cs_n  = 1'b0; // R3
					nxt_cnt   = CS_SETUP_CYC - 1'b1;
					nxt_state = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_sclk  = 1'b1;
					nxt_bit   = '0;
					nxt_cnt   = SCLK_HALF_CYC - 1'b1;
					nxt_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				// half period rounded up keeps sclk at or below 25 MHz
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1; // R10
				end else if (sclk_ff) begin
					nxt_sclk = 1'b0;
					nxt_cnt  = SCLK_HALF_CYC - 1'b1;
					if (bit_ff == BIT_LAST) begin
						nxt_cnt   = CS_HOLD_CYC - 1'b1;
						nxt_state = ST_HOLD;
					end else begin
						nxt_bit = bit_ff + 1'b1;
						nxt_sh  = {sh_ff[WORD_W-2:0], 1'b0};
						nxt_din = sh_ff[WORD_W-2]; // R2
					end
				end else begin
					nxt_sclk = 1'b1;
					nxt_cnt  = SCLK_HALF_CYC - 1'b1;
				end
			end
			ST_HOLD: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_cs_n  = 1'b1; // R4
					nxt_cnt   = CS_GAP_CYC - 1'b1;
					nxt_state = ST_GAP;
				end
			end
			ST_GAP: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else if (mode_ff) begin
					nxt_ld_n  = 1'b0; // R6
					nxt_cnt   = LOAD_PW_CYC - 1'b1;
					nxt_state = ST_LOAD;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
			ST_LOAD: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_ld_n  = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cs_n  = 1'b1;
				nxt_sclk  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= '0;
			bit_ff   <= '0;
			sh_ff    <= '0;
			mode_ff  <= 1'b1;
			sclk_ff  <= 1'b0;
			cs_n_ff  <= 1'b1;
			din_ff   <= 1'b0;
			ld_n_ff  <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			bit_ff   <= nxt_bit;
			sh_ff    <= nxt_sh;
			mode_ff  <= nxt_mode;
			sclk_ff  <= nxt_sclk;
			cs_n_ff  <= nxt_cs_n;
			din_ff   <= nxt_din;
			ld_n_ff  <= nxt_ld_n;
		end
	end

	// link pins straight from flip-flops, glitch free
	assign link.sclk                = sclk_ff;
	assign link.cs_n                = cs_n_ff;
	assign link.din                 = din_ff;
	assign link.latch_load_strobe_n = ld_n_ff;
	assign busy_out                 = (state_ff != ST_IDLE);
endmodule

// ===== test/sdl_link_sva.sv
// Purpose: concurrent checks on the serial link and the device outputs
// Assumes: every link wire comes from a flop on clk_in at the host
// Notes:   all sampling on clk_in; the serial clock is never a clock here

`timescale 1ns/100ps

module sdl_link_sva
	import sdl_pkg::*;
(
	input wire logic                       clk_in,
	input wire logic                       reset_in,
	input wire logic                       sclk,
	input wire logic                       din,
	input wire logic                       cs_n,
	input wire logic                       latch_load_strobe_n,
	input wire logic [sdl_pkg::WORD_W-1:0] latch_code_out,
	input wire logic [sdl_pkg::SEG_W-1:0]  segment_out,
	input wire logic [sdl_pkg::LAD_W-1:0]  ladder_out,
	input wire logic [sdl_pkg::WORD_W-1:0] input_word_out,
	input wire logic                       word_taken_out,
	input wire logic                       latch_update_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	// load pulses follow their cause within six edges (sync takes 3..4)
	sequence s_taken;
		1'b1 ##[1:6] word_taken_out;
	endsequence
	sequence s_loaded;
		1'b1 ##[1:6] latch_update_out;
	endsequence

	AST_CS_RISE_TAKES: assert property ($rose(cs_n) |-> s_taken)
		else $error("select rise did not move the word");
	AST_SYNC_LOAD: assert property (
		$rose(cs_n) && !latch_load_strobe_n |-> s_loaded)
		else $error("select rise with strobe low did not load latch");
	AST_ASYNC_LOAD: assert property (
		$fell(latch_load_strobe_n) && cs_n |-> s_loaded)
		else $error("strobe fall did not load latch");
	AST_LATCH_HOLD: assert property (
		$changed(latch_code_out) |-> latch_update_out)
		else $error("latch changed without a load");
	AST_INPUT_HOLD: assert property (
		$changed(input_word_out) |-> word_taken_out)
		else $error("input register changed without a frame end");
	AST_LATCH_FROM_INPUT: assert property (
		latch_update_out |-> latch_code_out == input_word_out)
		else $error("latch differs from input register on load");
	AST_SEG: assert property (
		segment_out ==
		SEG_W'((16'h0001 << latch_code_out[15:12]) - 16'h0001))
		else $error("segment controls not thermometer of top nibble");
	AST_LADDER: assert property (ladder_out == latch_code_out[11:0])
		else $error("ladder controls differ from low bits");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*5])
		else $error("serial clock high phase too short");
	AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk[*5])
		else $error("serial clock low phase too short");
	AST_CS_SETUP: assert property ($fell(cs_n) |-> !sclk[*4])
		else $error("serial clock rose too soon after select fall");
	AST_DIN_STEADY: assert property ($past(sclk) && sclk |-> $stable(din))
		else $error("data moved while serial clock high");
	AST_STROBE_FALL: assert property ($fell(latch_load_strobe_n) |-> cs_n)
		else $error("strobe fell inside a frame");
	AST_STROBE_RISE: assert property ($rose(latch_load_strobe_n) |-> cs_n)
		else $error("strobe rose inside a frame");
endmodule

// ===== test/serial_dac_load_logic_bench.sv
// Purpose: bench joining host and device ends over the serial link
// Assumes: the host divides the serial clock from clk_in
// Notes:   the driver queues expected words, the monitor pops them

`timescale 1ns/100ps

module serial_dac_load_logic_bench;
	import sdl_pkg::*;

	logic              clk_in;
	logic              reset_in;
	logic [WORD_W-1:0] word_in;
	logic              word_valid_in;
	logic              word_ready_out;
	logic              async_load_in;
	logic              busy_out;
	logic [WORD_W-1:0] latch_code_out;
	logic [SEG_W-1:0]  segment_out;
	logic [LAD_W-1:0]  ladder_out;
	logic [WORD_W-1:0] input_word_out;
	logic              word_taken_out;
	logic              latch_update_out;
	logic [WORD_W-1:0] exp_word[$];
	logic [WORD_W-1:0] exp_latch[$];
	logic [WORD_W-1:0] last_word;
	logic [WORD_W-1:0] lw;
	logic              full_seen;
	int                num_errors;
	int                checks;
	localparam logic [WORD_W-1:0] CORNER [4] = '{16'h0000, 16'hffff,
		16'h8000, 16'h0001};

	sdl_link_if link_bus ();
	sdl_host i_sdl_host (.clk_in(clk_in), .reset_in(reset_in),
		.word_in(word_in), .word_valid_in(word_valid_in),
		.word_ready_out(word_ready_out), .async_load_in(async_load_in),
		.busy_out(busy_out), .link(link_bus.host));
	sdl_device i_sdl_device (.clk_in(clk_in), .reset_in(reset_in),
		.link(link_bus.dev), .latch_code_out(latch_code_out),
		.segment_out(segment_out), .ladder_out(ladder_out),
		.input_word_out(input_word_out), .word_taken_out(word_taken_out),
		.latch_update_out(latch_update_out));
	sdl_link_sva i_sdl_link_sva (.clk_in(clk_in), .reset_in(reset_in),
		.sclk(link_bus.sclk), .din(link_bus.din), .cs_n(link_bus.cs_n),
		.latch_load_strobe_n(link_bus.latch_load_strobe_n),
		.latch_code_out(latch_code_out), .segment_out(segment_out),
		.ladder_out(ladder_out), .input_word_out(input_word_out),
		.word_taken_out(word_taken_out),
		.latch_update_out(latch_update_out));

	// 250 MHz system clock
	initial clk_in = 1'b0;
	always #2 clk_in = ~clk_in;

	task check(input string what, input logic [WORD_W-1:0] seen,
		input logic [WORD_W-1:0] exp);
		checks++;
		if (seen !== exp)
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		if (seen !== exp)
			num_errors++;
	endtask

	task end_of_test();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// valid stays up across a burst; ready is read mid-cycle to avoid races
	task push(input logic [WORD_W-1:0] w);
		logic r;
		word_in       <= w;
		word_valid_in <= 1'b1;
		do begin
			@(negedge clk_in);
			r = word_ready_out;
			if (r !== 1'b1)
				full_seen = 1'b1;
			@(posedge clk_in);
		end while (r !== 1'b1);
		exp_word.push_back(w);
		exp_latch.push_back(w);
		last_word = w;
	endtask

	// wait until every queued load has shown up and the host is idle
	task drain();
		word_valid_in <= 1'b0;
		for (int i = 0; i < 9000; i++) begin
			@(negedge clk_in);
			if (exp_latch.size() == 0 && busy_out === 1'b0)
				break;
		end
		// judged mid-cycle so no output is read at the edge that moves it
		check("pending words", WORD_W'(exp_word.size()), 16'h0000);
		check("pending loads", WORD_W'(exp_latch.size()), 16'h0000);
		check("host idle", WORD_W'(busy_out), 16'h0000);
		check("fifo ready", WORD_W'(word_ready_out), 16'h0001);
		@(posedge clk_in);
	endtask

	// a strobe fall while idle reloads the latch from the input register
	task set_mode(input logic a);
		async_load_in <= a;
		if (a == 1'b0)
			exp_latch.push_back(last_word);
		repeat (8) @(posedge clk_in);
	endtask

	// every pulse is compared with the oldest queued expectation
	// sampled on the falling edge, where the one-cycle pulses have settled
	always @(negedge clk_in) begin
		if (word_taken_out === 1'b1) begin
			lw = exp_word.size() ? exp_word.pop_front() : 16'hxxxx;
			check("input word", input_word_out, lw);
		end
		if (latch_update_out === 1'b1) begin
			lw = exp_latch.size() ? exp_latch.pop_front() : 16'hxxxx;
			check("latch code", latch_code_out, lw);
			check("segments", WORD_W'(segment_out),
				WORD_W'((16'h0001 << lw[15:12]) - 16'h0001));
			check("ladder", WORD_W'(ladder_out), WORD_W'(lw[11:0]));
		end
	end

	// a hung link ends the run here; a lost load fails the pending check in drain
	initial begin
		repeat (40000) @(posedge clk_in);
		num_errors++;
		end_of_test();
	end

	initial begin
		reset_in      = 1'b1;
		word_in       = 16'h0000;
		word_valid_in = 1'b0;
		async_load_in = 1'b1;
		full_seen     = 1'b0;
		last_word     = 16'h0000;
		num_errors    = 0;
		checks        = 0;
		void'($urandom(71));
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		@(negedge clk_in);
		check("latch after reset", latch_code_out, LATCH_RST);
		check("segments after reset", WORD_W'(segment_out), 16'h0000);
		check("ladder after reset", WORD_W'(ladder_out), 16'h0000);
		@(posedge clk_in);
		// strobed loads: corner codes, then every top nibble value
		foreach (CORNER[i])
			push(CORNER[i]);
		for (int t = 0; t < 16; t++)
			push({4'(t), 12'($urandom)});
		drain();
		// strobe held low: select rise loads; burst overfills the fifo
		set_mode(1'b0);
		for (int i = 0; i < 20; i++)
			push(16'($urandom));
		drain();
		check("fifo refused when full", WORD_W'(full_seen), 16'h0001);
		// back to strobed loads, strobe rise alone must not load
		set_mode(1'b1);
		for (int i = 0; i < 4; i++)
			push(16'($urandom));
		drain();
		end_of_test();
	end
endmodule
